// ==== src/asrc_pkg.sv ====
// Shared constants and types for the converter control and read-back block.
// Assumes a single 200 MHz system clock; all pins arrive unsynchronised.
package asrc_pkg;
   // System clock period
   localparam int CLK_PERIOD_NS = 5;
   // Converter conversion time and derived cycle count (rounded up)
   localparam int CONV_TIME_NS = 360000;
   localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // System clocks per reference oscillator period (10 MHz reference)
   localparam int OSC_RATIO = 20;
   // Acquisition window exponents: narrow and wide
   localparam int ACQ_EXP_NARROW = 19;
   localparam int ACQ_EXP_WIDE = 21;
   localparam int WIN_NARROW_CYC = (2 ** ACQ_EXP_NARROW) * OSC_RATIO;
   localparam int WIN_WIDE_CYC = (2 ** ACQ_EXP_WIDE) * OSC_RATIO;
   // Data widths
   localparam int ADC_W = 6;
   localparam int FCNT_W = 22;
   localparam int SHIFT_W = 24;
   localparam int BCNT_W = 5;
   // Transfer lengths that select a register, and the bit count ceiling
   localparam logic [4:0] LEN_CTRL = 5'h08;
   localparam logic [4:0] LEN_REF = 5'h18;
   localparam logic [4:0] LEN_MAX = 5'h1f;
   // Reference word field positions
   localparam int R_ACQ = 15;
   localparam int R_FSAMPLE = 14;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [FCNT_W-1:0] FCNT_PRESET = 22'h3fffff;
   localparam logic [FCNT_W-1:0] FCNT_ZERO = 22'h000000;
   localparam logic [SHIFT_W-1:0] SHIFT_ZERO = 24'h000000;
   // Pad below the ADC image
   localparam logic [14:0] ADC_PAD = 15'h0000;

   // Control word layout, most significant bit first
   typedef struct packed {
      logic adc_sample_bit;   // Start and hold a conversion
      logic read_a;           // Converter read-back request
      logic rsvd;             // Reserved, written as zero
      logic chan;             // 0 selects input A, 1 input B
      logic read_f;           // Frequency read-back request
      logic [2:0] gp;         // General purpose outputs C, B, A
   } asrc_ctrl_t;

   // Pins that need synchronising
   typedef struct packed {
      logic port_select_n;
      logic sclk;
      logic sdin;
      logic in_c;
      logic in_d;
      logic fin;
      logic [ADC_W-1:0] ain_a;
      logic [ADC_W-1:0] ain_b;
   } asrc_pins_t;

   // Serial port states
   typedef enum logic [0:0] {SER_IDLE, SER_FRAME} asrc_ser_t;
   // Frequency counter states
   typedef enum logic [1:0] {FC_PRESET, FC_COUNT, FC_HOLD} asrc_fc_t;
endpackage : asrc_pkg

// ==== src/asrc_adc.sv ====
// Converter sequencer: one conversion per rise of the sample bit, then hold.
// Assumes sample and channel come from registers on mclk; inputs already synced.
`timescale 1ns/10ps
module asrc_adc #(
   parameter int CONV_CYCLES = asrc_pkg::CONV_CYC
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic sample,
   input wire logic chan,
   input wire logic [asrc_pkg::ADC_W-1:0] ain_a,
   input wire logic [asrc_pkg::ADC_W-1:0] ain_b,
   output logic [asrc_pkg::ADC_W-1:0] value,
   output logic eoc
);
   logic [31:0] cnt_reg;                       // Conversion timer
   logic [31:0] cnt_next;
   logic busy_reg;                             // Conversion under way
   logic busy_next;
   logic eoc_reg;                              // End of conversion flag
   logic eoc_next;
   logic [asrc_pkg::ADC_W-1:0] val_reg;        // Held result
   logic [asrc_pkg::ADC_W-1:0] val_next;

   // Sequencer next state
   always_comb begin
      cnt_next = cnt_reg;
      busy_next = busy_reg;
      eoc_next = eoc_reg;
      val_next = val_reg;
      if (!sample) begin
         // Held initialised; flag dropped, result kept
         cnt_next = 32'h0;
         busy_next = 1'b0;
         eoc_next = 1'b0;
      end else if (!busy_reg && !eoc_reg) begin
         // Fresh start; channel was set by an earlier write
         busy_next = 1'b1;
         cnt_next = 32'h0;
      end else if (busy_reg) begin
         if (cnt_reg >= 32'(CONV_CYCLES - 1)) begin
            // Input A when chan low, B when high
            val_next = chan ? ain_b : ain_a;
            busy_next = 1'b0;
            eoc_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 32'h1;
         end
      end
   end

   // Sequencer registers
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= 32'h0;
         busy_reg <= 1'b0;
         eoc_reg <= 1'b0;
         val_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
         busy_reg <= busy_next;
         eoc_reg <= eoc_next;
         val_reg <= val_next;
      end
   end

   assign value = val_reg;
   assign eoc = eoc_reg;
endmodule : asrc_adc

// ==== src/asrc_top.sv ====
// Control word, converter and frequency read-back behind a four-wire serial port.
// Assumes the serial clock is far slower than mclk; every pin is synchronised here.
`timescale 1ns/10ps
module asrc_top #(
   parameter int CONV_CYCLES = asrc_pkg::CONV_CYC,
   parameter int WIN_NARROW = asrc_pkg::WIN_NARROW_CYC,
   parameter int WIN_WIDE = asrc_pkg::WIN_WIDE_CYC
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic port_select_n,
   input wire logic sclk,
   input wire logic sdin,
   output logic sdout,
   input wire logic input_c,
   input wire logic input_d,
   input wire logic freq_in,
   input wire logic [asrc_pkg::ADC_W-1:0] adc_in_a,
   input wire logic [asrc_pkg::ADC_W-1:0] adc_in_b,
   output logic [2:0] gp_out
);
   // Edge test shared by serial clock, select and frequency input
   function automatic logic edge_of(input logic prev, input logic cur, input logic rising);
      edge_of = rising ? (!prev && cur) : (prev && !cur);
   endfunction : edge_of

   asrc_pkg::asrc_pins_t pins_raw;             // Raw pin bundle
   asrc_pkg::asrc_pins_t s1_reg;               // First synchroniser stage
   asrc_pkg::asrc_pins_t s2_reg;               // Second stage, safe to use
   asrc_pkg::asrc_pins_t s3_reg;               // Previous value for edges

   assign pins_raw = '{port_select_n: port_select_n, sclk: sclk, sdin: sdin, in_c: input_c,
                       in_d: input_d, fin: freq_in, ain_a: adc_in_a, ain_b: adc_in_b};

   // Reset to the pins' idle levels; a low select here would fake an edge on release
   localparam asrc_pkg::asrc_pins_t PINS_IDLE = '{port_select_n: 1'b1, default: '0};

   // Two-stage synchroniser plus delay; stage one feeds only stage two
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s1_reg <= PINS_IDLE;
         s2_reg <= PINS_IDLE;
         s3_reg <= PINS_IDLE;
      end else begin
         s1_reg <= pins_raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Decoded pin events
   logic sclk_rise;
   logic sel_fall;
   logic sel_rise;
   logic fin_rise;
   assign sclk_rise = edge_of(s3_reg.sclk, s2_reg.sclk, 1'b1) && !s2_reg.port_select_n;
   assign sel_fall = edge_of(s3_reg.port_select_n, s2_reg.port_select_n, 1'b0);
   assign sel_rise = edge_of(s3_reg.port_select_n, s2_reg.port_select_n, 1'b1);
   assign fin_rise = edge_of(s3_reg.fin, s2_reg.fin, 1'b1);

   // Converter results
   logic [asrc_pkg::ADC_W-1:0] adc_value;
   logic adc_eoc;

   asrc_pkg::asrc_ctrl_t ctrl_reg;             // Control word
   asrc_pkg::asrc_ctrl_t ctrl_next;
   logic fsample_reg;                          // Frequency sample bit
   logic fsample_next;
   logic acq_wide_reg;                         // Wide acquisition window
   logic acq_wide_next;

   // Converter sequencer; sample bit is taken whatever the counter does
   asrc_adc #(
      .CONV_CYCLES(CONV_CYCLES)
   ) u_adc (
      .mclk(mclk),
      .rst_b(rst_b),
      .sample(ctrl_reg.adc_sample_bit),
      .chan(ctrl_reg.chan),
      .ain_a(s2_reg.ain_a),
      .ain_b(s2_reg.ain_b),
      .value(adc_value),
      .eoc(adc_eoc)
   );

   // Frequency counter state
   asrc_pkg::asrc_fc_t fc_state_reg;
   asrc_pkg::asrc_fc_t fc_state_next;
   logic [asrc_pkg::FCNT_W-1:0] fcnt_reg;      // Edge count
   logic [asrc_pkg::FCNT_W-1:0] fcnt_next;
   logic [31:0] win_reg;                       // Window timer
   logic [31:0] win_next;
   logic cc_reg;                               // Count complete
   logic cc_next;
   logic [31:0] win_len;
   assign win_len = acq_wide_reg ? 32'(WIN_WIDE) : 32'(WIN_NARROW);

   // Frequency counter next state
   always_comb begin
      fc_state_next = fc_state_reg;
      fcnt_next = fcnt_reg;
      win_next = win_reg;
      cc_next = cc_reg;
      case (fc_state_reg)
         asrc_pkg::FC_PRESET: begin
            // Preset to all ones while the sample bit is low
            fcnt_next = asrc_pkg::FCNT_PRESET;
            cc_next = 1'b0;
            win_next = 32'h0;
            if (fsample_reg) begin
               fcnt_next = asrc_pkg::FCNT_ZERO;
               fc_state_next = asrc_pkg::FC_COUNT;
            end
         end
         asrc_pkg::FC_COUNT: begin
            if (!fsample_reg) begin
               fc_state_next = asrc_pkg::FC_PRESET;
            end else if (win_reg >= win_len - 32'h1) begin
               // Window over: hold the count
               fc_state_next = asrc_pkg::FC_HOLD;
               cc_next = 1'b1;
            end else begin
               win_next = win_reg + 32'h1;
               if (fin_rise) begin
                  fcnt_next = fcnt_reg + 22'h1;
               end
            end
         end
         asrc_pkg::FC_HOLD: begin
            // Count stands until the sample bit drops
            if (!fsample_reg) begin
               fc_state_next = asrc_pkg::FC_PRESET;
            end
         end
         default: begin
            fc_state_next = asrc_pkg::FC_PRESET;
         end
      endcase
   end

   // Frequency counter registers
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         fc_state_reg <= asrc_pkg::FC_PRESET;
         fcnt_reg <= asrc_pkg::FCNT_PRESET;
         win_reg <= 32'h0;
         cc_reg <= 1'b0;
      end else begin
         fc_state_reg <= fc_state_next;
         fcnt_reg <= fcnt_next;
         win_reg <= win_next;
         cc_reg <= cc_next;
      end
   end

   // Read-back images, left aligned so the first bit leaves first
   logic [asrc_pkg::SHIFT_W-1:0] adc_image;
   logic [asrc_pkg::SHIFT_W-1:0] freq_image;
   // Input D sits in bit nine of the converter image, so an 8-bit converter read never carries it; the counter image has it second
   assign adc_image = {adc_eoc, s2_reg.in_c, adc_value, s2_reg.in_d, asrc_pkg::ADC_PAD};
   assign freq_image = {cc_reg, s2_reg.in_d, fcnt_reg};

   // Serial port state
   asrc_pkg::asrc_ser_t ser_reg;
   asrc_pkg::asrc_ser_t ser_next;
   logic [asrc_pkg::SHIFT_W-1:0] sh_in_reg;    // Incoming bits
   logic [asrc_pkg::SHIFT_W-1:0] sh_in_next;
   logic [asrc_pkg::SHIFT_W-1:0] sh_out_reg;   // Outgoing bits
   logic [asrc_pkg::SHIFT_W-1:0] sh_out_next;
   logic [asrc_pkg::BCNT_W-1:0] bcnt_reg;      // Bits seen this frame
   logic [asrc_pkg::BCNT_W-1:0] bcnt_next;
   logic sdout_reg;
   logic sdout_next;
   logic [2:0] gp_reg;
   logic [2:0] gp_next;

   // Serial port and register write next state
   always_comb begin
      ser_next = ser_reg;
      sh_in_next = sh_in_reg;
      sh_out_next = sh_out_reg;
      bcnt_next = bcnt_reg;
      ctrl_next = ctrl_reg;
      fsample_next = fsample_reg;
      acq_wide_next = acq_wide_reg;
      case (ser_reg)
         asrc_pkg::SER_IDLE: begin
            if (sel_fall) begin
               ser_next = asrc_pkg::SER_FRAME;
               bcnt_next = '0;
               // Converter request outranks frequency request
               if (ctrl_reg.read_a) begin
                  sh_out_next = adc_image;
               end else if (ctrl_reg.read_f) begin
                  sh_out_next = freq_image;
               end else begin
                  sh_out_next = asrc_pkg::SHIFT_ZERO;
               end
            end
         end
         asrc_pkg::SER_FRAME: begin
            if (sel_rise) begin
               ser_next = asrc_pkg::SER_IDLE;
               if (ctrl_reg.read_a) begin
                  // Writes blocked; request ends once data went out
                  if (bcnt_reg != '0) begin
                     ctrl_next.read_a = 1'b0;
                     ctrl_next.read_f = 1'b0;
                  end
               end else if (ctrl_reg.read_f) begin
                  if (bcnt_reg != '0) begin
                     ctrl_next.read_f = 1'b0;
                  end
               end else if (bcnt_reg == asrc_pkg::LEN_CTRL) begin
                  // Only a host write moves the sample bit
                  ctrl_next = asrc_pkg::asrc_ctrl_t'(sh_in_reg[7:0]);
                  if (ctrl_next.read_a) begin
                     ctrl_next.read_f = 1'b0;
                  end
               end else if (bcnt_reg == asrc_pkg::LEN_REF) begin
                  fsample_next = sh_in_reg[asrc_pkg::R_FSAMPLE];
                  acq_wide_next = sh_in_reg[asrc_pkg::R_ACQ];
               end
            end else if (sclk_rise) begin
               // Shift one bit each way, most significant first
               sh_in_next = {sh_in_reg[asrc_pkg::SHIFT_W-2:0], s2_reg.sdin};
               sh_out_next = {sh_out_reg[asrc_pkg::SHIFT_W-2:0], 1'b0};
               if (bcnt_reg != asrc_pkg::LEN_MAX) begin
                  bcnt_next = bcnt_reg + 5'h1;
               end
            end
         end
         default: begin
            ser_next = asrc_pkg::SER_IDLE;
         end
      endcase
      sdout_next = sh_out_next[asrc_pkg::SHIFT_W-1];
      gp_next = ctrl_next.gp;
   end

   // Serial port and control registers; all requests come up cleared
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ser_reg <= asrc_pkg::SER_IDLE;
         sh_in_reg <= asrc_pkg::SHIFT_ZERO;
         sh_out_reg <= asrc_pkg::SHIFT_ZERO;
         bcnt_reg <= '0;
         ctrl_reg <= asrc_pkg::CTRL_RESET;
         fsample_reg <= 1'b0;
         acq_wide_reg <= 1'b0;
         sdout_reg <= 1'b0;
         gp_reg <= 3'h0;
      end else begin
         ser_reg <= ser_next;
         sh_in_reg <= sh_in_next;
         sh_out_reg <= sh_out_next;
         bcnt_reg <= bcnt_next;
         ctrl_reg <= ctrl_next;
         fsample_reg <= fsample_next;
         acq_wide_reg <= acq_wide_next;
         sdout_reg <= sdout_next;
         gp_reg <= gp_next;
      end
   end

   // Outputs straight from flops
   assign sdout = sdout_reg;
   assign gp_out = gp_reg;
endmodule : asrc_top

// ==== bench/asrc_monitor.sv ====
// Pin-level checker for the converter control block.
// Assumes it is bound to asrc_top and sees only its pins.
`timescale 1ns/10ps
module asrc_monitor (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic port_select_n,
   input wire logic sclk,
   input wire logic sdout,
   input wire logic [2:0] gp_out
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // Cycles since the last serial pin event, saturating
   logic [3:0] age_reg;
   logic [3:0] age_next;
   // Previous pin levels for edge detection
   logic sclk_reg;
   logic sel_reg;
   // Restart on a link clock rise or any select change
   always_comb begin
      if ((sclk && !sclk_reg) || (port_select_n != sel_reg)) begin
         age_next = 4'h0;
      end else if (age_reg != 4'hf) begin
         age_next = age_reg + 4'h1;
      end else begin
         age_next = age_reg;
      end
   end
   // Register only
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         age_reg <= 4'hf;
         sclk_reg <= 1'b0;
         sel_reg <= 1'b1;
      end else begin
         age_reg <= age_next;
         sclk_reg <= sclk;
         sel_reg <= port_select_n;
      end
   end
   // Frame held open, and port left idle
   sequence s_frame_open;
      !port_select_n [*4];
   endsequence
   sequence s_port_idle;
      port_select_n [*8];
   endsequence
   a_sdout_reset_low: assert property ($rose(rst_b) |-> !sdout)
      else $error("sdout not low after reset");
   a_gp_reset_low: assert property ($rose(rst_b) |-> (gp_out == 3'h0) [*3])
      else $error("gp_out not clear after reset");
   a_gp_after_frame: assert property ($changed(gp_out) |-> $past(port_select_n, 1) && $past(port_select_n, 3))
      else $error("gp_out changed inside a frame");
   a_gp_frame_steady: assert property (s_frame_open |-> $stable(gp_out))
      else $error("gp_out moved during a frame");
   a_gp_quiet_late: assert property (port_select_n && age_reg == 4'hf |-> $stable(gp_out))
      else $error("gp_out moved with no frame");
   a_sdout_idle_hold: assert property (s_port_idle |=> $stable(sdout))
      else $error("sdout moved while port idle");
   a_sdout_low_clock: assert property ((!port_select_n && !sclk) [*8] |=> $stable(sdout))
      else $error("sdout moved with link clock low");
   a_sdout_has_cause: assert property ($changed(sdout) |-> age_reg <= 4'h7)
      else $error("sdout moved with no link event");
endmodule : asrc_monitor

bind asrc_top asrc_monitor i_mon (.mclk(mclk), .rst_b(rst_b), .port_select_n(port_select_n),
   .sclk(sclk), .sdout(sdout), .gp_out(gp_out));

// ==== bench/asrc_host_model.sv ====
// Host side of the four-wire port: frames, shifts MSB first, samples replies.
// Assumes mclk from the bench; pins change on its falling edge.
`timescale 1ns/10ps
module asrc_host_model (
   input wire logic mclk,
   output logic port_select_n,
   output logic sclk,
   output logic sdin,
   input wire logic sdout
);
   // Idle levels; link clock stands still outside frames
   initial begin
      port_select_n = 1'b1;
      sclk = 1'b0;
      sdin = 1'b0;
   end
   // One frame of n bits; link clock period 125 ns
   task automatic xfer(input int n, input logic [23:0] wd, output logic [23:0] rd);
      rd = 24'h000000;
      @(negedge mclk) port_select_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         sdin = wd[i];
         repeat (12) @(negedge mclk);
         // Sample before the rise, the device changes on it
         rd = {rd[22:0], sdout};
         sclk = 1'b1;
         repeat (13) @(negedge mclk);
         sclk = 1'b0;
      end
      repeat (12) @(negedge mclk);
      port_select_n = 1'b1;
      // Released line shows the inverse, never a stale bit
      sdin = ~sdin;
      repeat (16) @(negedge mclk);
   endtask : xfer
endmodule : asrc_host_model

// ==== bench/tb_top.sv ====
// Self-checking bench: control writes, converter and counter read-back.
// Assumes the host model drives the serial pins; other pins come from here.
`timescale 1ns/10ps
module tb_top;
   // Short counts keep the run brief
   localparam int CONV = 20;
   localparam int WIN = 50;
   localparam int LIMIT = 40000;
   logic mclk;
   logic rst_b;
   logic port_select_n;
   logic sclk;
   logic sdin;
   logic sdout;
   logic input_c;
   logic input_d;
   logic freq_in;
   logic [asrc_pkg::ADC_W-1:0] adc_in_a;
   logic [asrc_pkg::ADC_W-1:0] adc_in_b;
   logic [2:0] gp_out;
   logic [23:0] r;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   asrc_top #(.CONV_CYCLES(CONV), .WIN_NARROW(WIN), .WIN_WIDE(2 * WIN)) i_dut (.mclk(mclk), .rst_b(rst_b),
      .port_select_n(port_select_n), .sclk(sclk), .sdin(sdin), .sdout(sdout), .input_c(input_c),
      .input_d(input_d), .freq_in(freq_in), .adc_in_a(adc_in_a), .adc_in_b(adc_in_b), .gp_out(gp_out));
   asrc_host_model i_host (.mclk(mclk), .port_select_n(port_select_n), .sclk(sclk), .sdin(sdin), .sdout(sdout));
   // 200 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Compare and count
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Control byte write; reply discarded; callers keep bit 5 clear
   task automatic wr(input logic [7:0] b);
      i_host.xfer(8, {16'h0000, b}, r);
   endtask : wr
   task automatic close_out();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out
   // Outputs follow the control byte
   task automatic sc_gp();
      check({21'h0, gp_out}, 24'h000000);
      wr(8'h05);
      check({21'h0, gp_out}, 24'h000005);
   endtask : sc_gp
   // Channel A conversion then 8-bit read-back
   task automatic sc_conv_a();
      wr(8'h00);
      wr(8'h80);
      repeat (CONV + 8) @(negedge mclk);
      wr(8'hc5);
      i_host.xfer(8, 24'h000082, r);
      check(r, {16'h0, 1'b1, input_c, adc_in_a});
      check({21'h0, gp_out}, 24'h000005);
      wr(8'h83);
      check({21'h0, gp_out}, 24'h000003);
   endtask : sc_conv_a
   // Sample low keeps value (9-bit read); channel B with 16 and 8 bits
   task automatic sc_conv_b();
      input_d = 1'b1;
      input_c = 1'b0;
      wr(8'h13);
      wr(8'h53);
      i_host.xfer(9, 24'h000000, r);
      check(r, {15'h0, 1'b0, input_c, adc_in_a, input_d});
      wr(8'h93);
      repeat (CONV + 8) @(negedge mclk);
      wr(8'hd3);
      i_host.xfer(16, 24'h000000, r);
      check(r, {8'h0, 1'b1, input_c, adc_in_b, input_d, 7'h00});
      wr(8'hd3);
      i_host.xfer(8, 24'h000000, r);
      check(r, {16'h0, 1'b1, input_c, adc_in_b});
   endtask : sc_conv_b
   // Both requests: converter wins, counter request dropped
   task automatic sc_both();
      wr(8'hcb);
      i_host.xfer(8, 24'h000000, r);
      check(r, {16'h0, 1'b1, input_c, adc_in_b});
      wr(8'h86);
      check({21'h0, gp_out}, 24'h000006);
   endtask : sc_both
   // Counter: three pulses in the window, then preset
   task automatic sc_freq();
      i_host.xfer(24, 24'h004000, r);
      repeat (3) begin
         freq_in = 1'b1;
         repeat (4) @(negedge mclk);
         freq_in = 1'b0;
         repeat (4) @(negedge mclk);
      end
      repeat (WIN) @(negedge mclk);
      wr(8'h88);
      i_host.xfer(24, 24'h000000, r);
      check(r, {1'b1, input_d, 22'h000003});
      i_host.xfer(24, 24'h000000, r);
      wr(8'h88);
      i_host.xfer(24, 24'h000000, r);
      check(r, {1'b0, input_d, 22'h3fffff});
   endtask : sc_freq
   // Wide window: a pulse after the narrow window still counts
   task automatic sc_freq_wide();
      i_host.xfer(24, 24'h00c000, r);
      repeat (WIN) @(negedge mclk);
      freq_in = 1'b1;
      repeat (4) @(negedge mclk);
      freq_in = 1'b0;
      repeat (WIN + 4) @(negedge mclk);
      wr(8'h88);
      i_host.xfer(24, 24'h000000, r);
      check(r, {1'b1, input_d, 22'h000001});
   endtask : sc_freq_wide
   // Main sequence
   initial begin
      rst_b = 1'b0;
      input_c = 1'b1;
      input_d = 1'b0;
      freq_in = 1'b0;
      adc_in_a = 6'h2d;
      adc_in_b = 6'h13;
      repeat (6) @(negedge mclk);
      rst_b = 1'b1;
      repeat (6) @(negedge mclk);
      sc_gp();
      sc_conv_a();
      sc_conv_b();
      sc_both();
      sc_freq();
      sc_freq_wide();
      close_out();
   end
   // Hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         close_out();
      end
   end
endmodule : tb_top
